// ---- logic/mfit_pkg.sv ----
// shared constants for the interrupt aggregation and time base block
package mfit_pkg;
   localparam logic [7:0] OFF_TIME_BASE_ONE_CONTROL  = 8'h00;
   localparam logic [7:0] OFF_PSC   = 8'h04;
   localparam logic [7:0] OFF_CTRL  = 8'h08;
   localparam logic [7:0] OFF_GEN   = 8'h0c;
   localparam logic [7:0] OFF_GFLAG = 8'h10;
   localparam logic [7:0] OFF_SEN   = 8'h14;
   localparam logic [7:0] OFF_SFLAG = 8'h18;
   localparam logic [7:0] TIME_BASE_ONE_CONTROL_RST  = 8'h00;
   localparam logic [1:0] PSC_RST   = 2'h0;
   localparam int TIME_BASE_ONE_CONTROL_EN_BIT = 7;
   localparam int CTRL_GIE_BIT = 0;
   localparam int CTRL_BUSY_BIT = 1;
   localparam int NSRC = 10;
   localparam int NGRP = 4;
   localparam int NVEC = 6;
   localparam int SRC_TM0P = 0;
   localparam int SRC_SPI = 8;
   localparam int SRC_TB1 = 9;
   localparam int VEC_SPI = 4;
   localparam int VEC_TB1 = 5;
   // group members: tm0 pair, tm1 pair, eeprom+low voltage, serial+two wire
   localparam logic [NGRP-1:0][NSRC-1:0] GRP_MASK = {10'h0c0, 10'h030, 10'h00c, 10'h003};
   localparam int TB_BASE_EXP = 8;
   localparam int TB_CNT_W = 15;
   localparam logic [1:0] PSC_SYS = 2'h0;
   localparam logic [1:0] PSC_DIV4 = 2'h1;
   localparam logic [1:0] DIV4_LAST = 2'h3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {
      SVC_IDLE = 2'b01,
      SVC_BUSY = 2'b10
   } mfit_svc_e;
endpackage

// ---- logic/mfit_top.sv ----
// interrupt aggregation, wake-up and second time base with axi4-lite registers
`timescale 1ns/100ps
`default_nettype none
module mfit_top #(
   parameter int NTM = 2
) (
   input  wire logic                 sys_clk,
   input  wire logic                 reset,
   input  wire logic                 ce,
   input  wire logic [7:0]           s_axi_awaddr,
   input  wire logic                 s_axi_awvalid,
   output logic                      s_axi_awready,
   input  wire logic [31:0]          s_axi_wdata,
   input  wire logic [3:0]           s_axi_wstrb,
   input  wire logic                 s_axi_wvalid,
   output logic                      s_axi_wready,
   output logic [1:0]                s_axi_bresp,
   output logic                      s_axi_bvalid,
   input  wire logic                 s_axi_bready,
   input  wire logic [7:0]           s_axi_araddr,
   input  wire logic                 s_axi_arvalid,
   output logic                      s_axi_arready,
   output logic [31:0]               s_axi_rdata,
   output logic [1:0]                s_axi_rresp,
   output logic                      s_axi_rvalid,
   input  wire logic                 s_axi_rready,
   input  wire logic [NTM-1:0]       timer_compare_p_evt,
   input  wire logic [NTM-1:0]       timer_compare_a_evt,
   input  wire logic                 eeprom_write_end,
   input  wire logic                 low_voltage_pin,
   input  wire logic [5:0]           serial_port_cond,
   input  wire logic [2:0]           two_wire_cond,
   input  wire logic [1:0]           four_wire_cond,
   input  wire logic                 subclock_pin,
   input  wire logic                 stack_full,
   input  wire logic                 irq_ack,
   input  wire logic                 ret_exec,
   input  wire logic                 return_from_interrupt_instruction,
   input  wire logic                 low_power_mode,
   output logic                      irq_req,
   output logic [2:0]                irq_vector,
   output logic                      pc_push,
   output logic                      wake_up
);
   localparam int NSRC     = mfit_pkg::NSRC;
   localparam int NGRP     = mfit_pkg::NGRP;
   localparam int NVEC     = mfit_pkg::NVEC;
   localparam int TB_CNT_W = mfit_pkg::TB_CNT_W;
   logic [15:0]           sflag_m, sen_m;
   logic                  lv_s1_r, lv_s2_r;
   logic                  sub_s1_r, sub_s2_r, sub_s3_r;
   logic [1:0]            div4_r;
   logic [1:0]            psc_sel_r;
   logic                  tb_en_r;
   logic [2:0]            tb_per_r;
   logic [TB_CNT_W-1:0]   tb_cnt_r;
   logic [15:0]           tb_lim;
   logic                  psc_tick, tb_ovf;
   logic [NSRC-1:0]       src_en_r, src_flag_r, src_set, src_clr;
   logic [NGRP-1:0]       grp_en_r, grp_flag_r, grp_set;
   logic [NSRC+NGRP-1:0]  all_prev_r;
   logic                  gie_r;
   mfit_pkg::mfit_svc_e   svc_r;
   logic [NVEC-1:0]       cand, vec_oh;
   logic                  ack_take;
   logic                  aw_hold_r, w_hold_r;
   logic [5:0]            aw_idx_r;
   logic [31:0]           w_data_r;
   logic [3:0]            w_strb_r;
   logic                  do_wr, wr_hit;
   logic                  wr_tb, wr_psc, wr_ctrl, wr_gen, wr_gflag, wr_sen, wr_sflag;
   logic                  bvalid_r, rvalid_r;
   logic [1:0]            bresp_r, rresp_r;
   logic [31:0]           rdata_r, rd_val;
   logic                  rd_hit;
   logic [7:0]            time_base_one_control_rd;

   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                           input logic [3:0] s);
      merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction

   // pin inputs: two stages before any use
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         lv_s1_r  <= 1'b0;
         lv_s2_r  <= 1'b0;
         sub_s1_r <= 1'b0;
         sub_s2_r <= 1'b0;
         sub_s3_r <= 1'b0;
      end else if (ce) begin
         lv_s1_r  <= low_voltage_pin;
         lv_s2_r  <= lv_s1_r;
         sub_s1_r <= subclock_pin;
         sub_s2_r <= sub_s1_r;
         sub_s3_r <= sub_s2_r;
      end
   end

   // prescaler source
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         div4_r <= 2'h0;
      end else if (ce) begin
         div4_r <= div4_r + 2'h1;
      end
   end

   always_comb begin
      case (psc_sel_r)
         mfit_pkg::PSC_SYS:  psc_tick = 1'b1;
         mfit_pkg::PSC_DIV4: psc_tick = (div4_r == mfit_pkg::DIV4_LAST);
         default:            psc_tick = sub_s2_r & ~sub_s3_r;
      endcase
   end

   // time base; >= guards a period shortened while the count is high
   // four-bit shift amount: exponent reaches 15
   assign tb_lim = (16'h0001 << (4'(mfit_pkg::TB_BASE_EXP) + {1'b0, tb_per_r})) - 16'h0001;
   assign tb_ovf = tb_en_r & psc_tick & (tb_cnt_r >= tb_lim[TB_CNT_W-1:0]);

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         tb_cnt_r <= '0;
      end else if (ce) begin
         if (!tb_en_r || tb_ovf) begin
            tb_cnt_r <= '0;
         end else if (psc_tick) begin
            tb_cnt_r <= tb_cnt_r + 15'h1;
         end
      end
   end

   // request sources
   generate
      for (genvar t = 0; t < NTM; t++) begin : g_tm
         assign src_set[mfit_pkg::SRC_TM0P + 2*t]     = timer_compare_p_evt[t];
         assign src_set[mfit_pkg::SRC_TM0P + 2*t + 1] = timer_compare_a_evt[t];
      end
   endgenerate
   assign src_set[4] = eeprom_write_end;
   assign src_set[5] = lv_s2_r;
   assign src_set[6] = |serial_port_cond;
   assign src_set[7] = |two_wire_cond;
   assign src_set[mfit_pkg::SRC_SPI] = |four_wire_cond;
   assign src_set[mfit_pkg::SRC_TB1] = tb_ovf;

   // only independently vectored sources lose their flag on service
   assign src_clr = {NSRC{ack_take}} & {vec_oh[mfit_pkg::VEC_TB1], vec_oh[mfit_pkg::VEC_SPI], 8'h00};

   assign sflag_m = wr_sflag ? merge16({6'h00, src_flag_r}, w_data_r, w_strb_r) : {6'h00, src_flag_r};
   assign sen_m   = merge16({6'h00, src_en_r}, w_data_r, w_strb_r);

   // set wins over clear; software may also preset flags to mask wake-up
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         src_flag_r <= '0;
      end else if (ce) begin
         src_flag_r <= (sflag_m[NSRC-1:0] & ~src_clr) | src_set;
      end
   end

   generate
      for (genvar g = 0; g < NGRP; g++) begin : g_grp
         assign grp_set[g] = |(src_set & src_en_r & mfit_pkg::GRP_MASK[g]);
         always_ff @(posedge sys_clk) begin
            if (reset) begin
               grp_flag_r[g] <= 1'b0;
            end else if (ce) begin
               if (grp_set[g]) begin
                  grp_flag_r[g] <= 1'b1;
               end else if (ack_take && vec_oh[g]) begin
                  grp_flag_r[g] <= 1'b0;
               end else if (wr_gflag && w_strb_r[0]) begin
                  grp_flag_r[g] <= w_data_r[g];
               end
            end
         end
      end
   endgenerate

   // vectoring
   assign cand = {src_en_r[mfit_pkg::SRC_TB1] & src_flag_r[mfit_pkg::SRC_TB1],
                  src_en_r[mfit_pkg::SRC_SPI] & src_flag_r[mfit_pkg::SRC_SPI],
                  grp_en_r & grp_flag_r};
   assign vec_oh = cand & (~cand + 6'h01);
   assign irq_req = ce & gie_r & ~stack_full & (|cand);
   assign ack_take = irq_ack & irq_req;
   assign pc_push = ack_take;

   always_comb begin
      irq_vector = 3'h0;
      for (int v = NVEC - 1; v >= 0; v--) begin
         if (cand[v]) begin
            irq_vector = 3'(v);
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         gie_r <= 1'b0;
      end else if (ce) begin
         if (ack_take) begin
            gie_r <= 1'b0;
         end else if (return_from_interrupt_instruction) begin
            gie_r <= 1'b1;
         end else if (wr_ctrl && w_strb_r[0]) begin
            gie_r <= w_data_r[mfit_pkg::CTRL_GIE_BIT];
         end
      end
   end

   // service state, visible to software
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         svc_r <= mfit_pkg::SVC_IDLE;
      end else if (ce) begin
         case (svc_r)
            mfit_pkg::SVC_IDLE: if (ack_take) svc_r <= mfit_pkg::SVC_BUSY;
            mfit_pkg::SVC_BUSY: begin
               if (ret_exec || return_from_interrupt_instruction) begin
                  svc_r <= mfit_pkg::SVC_IDLE;
               end
            end
            default: svc_r <= mfit_pkg::SVC_IDLE;
         endcase
      end
   end

   // wake-up ignores enables on purpose
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         all_prev_r <= '0;
         wake_up    <= 1'b0;
      end else if (ce) begin
         all_prev_r <= {grp_flag_r, src_flag_r};
         wake_up    <= low_power_mode & (|({grp_flag_r, src_flag_r} & ~all_prev_r));
      end
   end

   // axi4-lite write path
   assign s_axi_awready = ce & ~aw_hold_r & ~bvalid_r;
   assign s_axi_wready  = ce & ~w_hold_r & ~bvalid_r;
   assign do_wr = aw_hold_r & w_hold_r & ~bvalid_r;
   assign wr_tb    = do_wr && (aw_idx_r == mfit_pkg::OFF_TIME_BASE_ONE_CONTROL[7:2]);
   assign wr_psc   = do_wr && (aw_idx_r == mfit_pkg::OFF_PSC[7:2]);
   assign wr_ctrl  = do_wr && (aw_idx_r == mfit_pkg::OFF_CTRL[7:2]);
   assign wr_gen   = do_wr && (aw_idx_r == mfit_pkg::OFF_GEN[7:2]);
   assign wr_gflag = do_wr && (aw_idx_r == mfit_pkg::OFF_GFLAG[7:2]);
   assign wr_sen   = do_wr && (aw_idx_r == mfit_pkg::OFF_SEN[7:2]);
   assign wr_sflag = do_wr && (aw_idx_r == mfit_pkg::OFF_SFLAG[7:2]);
   assign wr_hit = wr_tb | wr_psc | wr_ctrl | wr_gen | wr_gflag | wr_sen | wr_sflag;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         aw_hold_r <= 1'b0;
         w_hold_r  <= 1'b0;
         aw_idx_r  <= 6'h00;
         w_data_r  <= 32'h0;
         w_strb_r  <= 4'h0;
         bvalid_r  <= 1'b0;
         bresp_r   <= mfit_pkg::RESP_OKAY;
      end else if (ce) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_r <= 1'b1;
            aw_idx_r  <= s_axi_awaddr[7:2];
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
         if (do_wr) begin
            aw_hold_r <= 1'b0;
            w_hold_r  <= 1'b0;
            bvalid_r  <= 1'b1;
            bresp_r   <= wr_hit ? mfit_pkg::RESP_OKAY : mfit_pkg::RESP_SLVERR;
         end else if (bvalid_r && s_axi_bready) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   // software registers
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         tb_en_r   <= mfit_pkg::TIME_BASE_ONE_CONTROL_RST[mfit_pkg::TIME_BASE_ONE_CONTROL_EN_BIT];
         tb_per_r  <= mfit_pkg::TIME_BASE_ONE_CONTROL_RST[2:0];
         psc_sel_r <= mfit_pkg::PSC_RST;
         grp_en_r  <= '0;
         src_en_r  <= '0;
      end else if (ce) begin
         if (wr_tb && w_strb_r[0]) begin
            tb_en_r  <= w_data_r[mfit_pkg::TIME_BASE_ONE_CONTROL_EN_BIT];
            tb_per_r <= w_data_r[2:0];
         end
         if (wr_psc && w_strb_r[0]) begin
            psc_sel_r <= w_data_r[1:0];
         end
         if (wr_gen && w_strb_r[0]) begin
            grp_en_r <= w_data_r[NGRP-1:0];
         end
         if (wr_sen) begin
            src_en_r <= sen_m[NSRC-1:0];
         end
      end
   end

   // read path
   assign time_base_one_control_rd = {tb_en_r, 4'h0, tb_per_r};

   always_comb begin
      rd_val = 32'h0;
      rd_hit = 1'b1;
      case (s_axi_araddr[7:2])
         mfit_pkg::OFF_TIME_BASE_ONE_CONTROL[7:2]:  rd_val = {24'h0, time_base_one_control_rd};
         mfit_pkg::OFF_PSC[7:2]:   rd_val = {30'h0, psc_sel_r};
         mfit_pkg::OFF_CTRL[7:2]:  rd_val = {30'h0, svc_r == mfit_pkg::SVC_BUSY, gie_r};
         mfit_pkg::OFF_GEN[7:2]:   rd_val = {28'h0, grp_en_r};
         mfit_pkg::OFF_GFLAG[7:2]: rd_val = {28'h0, grp_flag_r};
         mfit_pkg::OFF_SEN[7:2]:   rd_val = {22'h0, src_en_r};
         mfit_pkg::OFF_SFLAG[7:2]: rd_val = {22'h0, src_flag_r};
         default:                  rd_hit = 1'b0;
      endcase
   end

   assign s_axi_arready = ce & ~rvalid_r;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         rvalid_r <= 1'b0;
         rdata_r  <= 32'h0;
         rresp_r  <= mfit_pkg::RESP_OKAY;
      end else if (ce) begin
         if (s_axi_arvalid && s_axi_arready) begin
            rvalid_r <= 1'b1;
            rdata_r  <= rd_val;
            rresp_r  <= rd_hit ? mfit_pkg::RESP_OKAY : mfit_pkg::RESP_SLVERR;
         end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
         end
      end
   end

   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp  = bresp_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata  = rdata_r;
   assign s_axi_rresp  = rresp_r;

   // checks
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (reset);

   sequence s_flag_rise;
      ce && low_power_mode && (|({grp_flag_r, src_flag_r} & ~all_prev_r));
   endsequence
   sequence s_service;
      ce && ack_take;
   endsequence

   property p_tb_stop;
      ce && !tb_en_r |=> tb_cnt_r == 15'h0;
   endproperty
   a_tb_stop: assert property (p_tb_stop) else $error("time base counted while off");

   property p_tb_period;
      ce && tb_en_r && psc_tick && tb_per_r == 3'h0 && tb_cnt_r == 15'h00ff |=> src_flag_r[9];
   endproperty
   a_tb_period: assert property (p_tb_period) else $error("time base overflow missing");

   property p_rsvd_zero;
      s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h00 |=> s_axi_rdata[6:3] == 4'h0;
   endproperty
   a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved control bits nonzero");

   property p_grp_set;
      ce && grp_set[0] |=> grp_flag_r[0];
   endproperty
   a_grp_set: assert property (p_grp_set) else $error("group flag not set");

   property p_stack_full;
      stack_full |-> !irq_req;
   endproperty
   a_stack_full: assert property (p_stack_full) else $error("request with stack full");

   property p_gie_gate;
      !gie_r |-> !irq_req;
   endproperty
   a_gie_gate: assert property (p_gie_gate) else $error("request with global enable low");

   property p_service_clear;
      s_service and !return_from_interrupt_instruction |=> !gie_r;
   endproperty
   a_service_clear: assert property (p_service_clear) else $error("global enable kept on service");

   property p_member_kept;
      s_service and src_flag_r[0] && !wr_sflag |=> src_flag_r[0];
   endproperty
   a_member_kept: assert property (p_member_kept) else $error("member flag lost on service");

   property p_wake;
      s_flag_rise |=> wake_up;
   endproperty
   a_wake: assert property (p_wake) else $error("no wake on rising flag");

   property p_return_from_interrupt_instruction;
      ce && return_from_interrupt_instruction && !ack_take |=>
         gie_r ##1 (gie_r || $past(ack_take) || $past(wr_ctrl));
   endproperty
   a_return_from_interrupt_instruction: assert property (p_return_from_interrupt_instruction) else $error("return_from_interrupt_instruction left global enable low");

   property p_one_winner;
      irq_req |-> $onehot(vec_oh) && vec_oh[irq_vector];
   endproperty
   a_one_winner: assert property (p_one_winner) else $error("vector choice not unique");
endmodule
`default_nettype wire

// ---- logic/mfit_unused.sv ----
// holds no logic; the whole block lives in mfit_top
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// ---- verification/mfit_core_model.sv ----
// core sequencer model: takes vectors and tracks return stack depth
`timescale 1ns/100ps
`default_nettype none
module mfit_core_model #(
   parameter int DEPTH = 1
) (
   input  wire logic sys_clk,
   input  wire logic reset,
   input  wire logic ack_en,
   input  wire logic irq_req,
   input  wire logic pc_push,
   input  wire logic ret_any,
   output logic      irq_ack,
   output logic      stack_full
);
   int depth_r;
   // shallow stack on purpose so a nested entry finds it full
   assign stack_full = depth_r >= DEPTH;
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         depth_r <= 0;
      end
      else begin
         // only the return address goes on the stack
         depth_r <= depth_r + (pc_push ? 1 : 0) - ((ret_any && depth_r > 0) ? 1 : 0);
      end
   end
   // one-cycle take; ack_en low models a slow core
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         irq_ack <= 1'b0;
      end
      else begin
         irq_ack <= ack_en && irq_req && !irq_ack;
      end
   end
endmodule
`default_nettype wire

// ---- verification/tb.sv ----
// self-checking bench for the interrupt aggregation and time base block
`timescale 1ns/100ps
`default_nettype none
module tb;
   localparam logic [7:0] AF = mfit_pkg::OFF_SFLAG;
   localparam logic [7:0] AG = mfit_pkg::OFF_GFLAG;
   localparam logic [7:0] AS = mfit_pkg::OFF_SEN;
   localparam logic [7:0] AC = mfit_pkg::OFF_CTRL;
   logic        sys_clk = 1'b0;
   logic        reset = 1'b1;
   logic        ce = 1'b1;
   logic [7:0]  s_axi_awaddr = 8'h00;
   logic [7:0]  s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic        s_axi_awvalid = 1'b0;
   logic        s_axi_wvalid = 1'b0;
   logic        s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0;
   logic        s_axi_rready = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic [15:0] evv = 16'h0;
   logic [1:0]  timer_compare_p_evt, timer_compare_a_evt, four_wire_cond;
   logic [5:0]  serial_port_cond;
   logic [2:0]  two_wire_cond, irq_vector;
   logic        eeprom_write_end, stack_full, irq_ack, irq_req, pc_push, wake_up;
   logic        low_voltage_pin = 1'b0;
   logic        subclock_pin = 1'b0;
   logic        ret_exec = 1'b0;
   logic        return_from_interrupt_instruction = 1'b0;
   logic        low_power_mode = 1'b0;
   logic        ack_en = 1'b0;
   logic [33:0] bq[$];
   logic [33:0] vq[$];
   int          fails = 0;
   int          checks = 0;
   int          wakes = 0;
   int          sc = 0;
   assign {four_wire_cond, two_wire_cond, serial_port_cond, eeprom_write_end, timer_compare_a_evt,
           timer_compare_p_evt} = evv;
   mfit_top #(.NTM(2)) mfit_top_inst (.*);
   mfit_core_model #(.DEPTH(1)) mfit_core_model_inst (
      .sys_clk    (sys_clk),
      .reset      (reset),
      .ack_en     (ack_en),
      .irq_req    (irq_req),
      .pc_push    (pc_push),
      .ret_any    (ret_exec | return_from_interrupt_instruction),
      .irq_ack    (irq_ack),
      .stack_full (stack_full)
   );
   always #4 sys_clk = ~sys_clk;
   // slow subclock, ten system cycles a period
   always @(posedge sys_clk) begin
      sc <= (sc == 4) ? 0 : sc + 1;
      if (sc == 4) subclock_pin <= ~subclock_pin;
   end
   task automatic cmp(input logic [33:0] g, input logic [33:0] e);
      checks++;
      if (g !== e) begin
         fails++;
         $display("ERROR at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   always @(negedge sys_clk) begin
      if (s_axi_rvalid && s_axi_rready) cmp({s_axi_rresp, s_axi_rdata}, bq.pop_front());
      if (s_axi_bvalid && s_axi_bready) cmp({s_axi_bresp, 32'h0}, bq.pop_front());
      if (pc_push === 1'b1) cmp(34'(irq_vector), vq.pop_front());
      if (wake_up === 1'b1) wakes++;
   end
   task automatic complete_run;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("[ PASS ]");
      end
      else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic guard(input int n);
      if (n > 60) begin
         fails++;
         complete_run();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
      logic ta, tw, tb;
      int n;
      bq.push_back({er, 32'h0});
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      n = 0;
      tb = 1'b0;
      while (!tb) begin
         @(negedge sys_clk);
         ta = s_axi_awvalid && s_axi_awready;
         tw = s_axi_wvalid && s_axi_wready;
         tb = s_axi_bvalid;
         n++;
         guard(n);
         @(posedge sys_clk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
      tick(1);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
      logic ta, tr;
      int n;
      bq.push_back({er, e});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      n = 0;
      tr = 1'b0;
      while (!tr) begin
         @(negedge sys_clk);
         ta = s_axi_arvalid && s_axi_arready;
         tr = s_axi_rvalid;
         n++;
         guard(n);
         @(posedge sys_clk);
         if (ta) s_axi_arvalid <= 1'b0;
      end
      s_axi_rready <= 1'b0;
      tick(1);
   endtask
   task automatic pulse(input logic [15:0] m);
      evv <= m;
      tick(1);
      evv <= 16'h0;
      tick(1);
   endtask
   task automatic back(input logic full);
      if (full) return_from_interrupt_instruction <= 1'b1;
      else ret_exec <= 1'b1;
      tick(1);
      return_from_interrupt_instruction <= 1'b0;
      ret_exec <= 1'b0;
      tick(3);
   endtask
   task automatic req_low;
      @(negedge sys_clk);
      cmp(34'(irq_req), 34'h0);
      @(posedge sys_clk);
   endtask
   // source flag position of each event bit
   function automatic int sbit(input int i);
      if (i < 2) return 2 * i;
      if (i < 4) return 2 * i - 3;
      if (i == 4) return 4;
      if (i < 11) return 6;
      if (i < 14) return 7;
      return 8;
   endfunction
   initial begin
      logic [31:0] r;
      logic [3:0]  g;
      int          w;
      int          t;
      int          tc[4] = '{0, 0, 0, 7};
      int          tp[4] = '{0, 1, 2, 0};
      int          tf[4] = '{1, 4, 10, 1};
      void'($urandom(32'h5ecf));
      tick(12);
      reset <= 1'b0;
      tick(1);
      for (int a = 0; a < 7; a++) rd(8'(4 * a), 32'h0);
      rd(8'h40, 32'h0, mfit_pkg::RESP_SLVERR);
      wr(8'h40, 32'h1, mfit_pkg::RESP_SLVERR);
      wr(mfit_pkg::OFF_TIME_BASE_ONE_CONTROL, 32'hff);
      rd(mfit_pkg::OFF_TIME_BASE_ONE_CONTROL, 32'h87);
      wr(mfit_pkg::OFF_TIME_BASE_ONE_CONTROL, 32'h0);
      for (int i = 0; i < 4; i++) begin
         r = $urandom & 32'h3ff;
         wr(AS, r);
         rd(AS, r);
      end
      wr(AS, 32'h3ff);
      s_axi_wstrb <= 4'h1;
      wr(AS, 32'h0);
      s_axi_wstrb <= 4'hf;
      rd(AS, 32'h300);
      $display("test registers finished");
      // margins absorb prescaler phase and subclock sync delay
      for (int i = 0; i < 4; i++) begin
         t = (1 << (8 + tc[i])) * tf[i];
         wr(AF, 32'h0);
         wr(mfit_pkg::OFF_PSC, 32'(tp[i]));
         wr(mfit_pkg::OFF_TIME_BASE_ONE_CONTROL, 32'h80 | 32'(tc[i]));
         tick(t / 2);
         rd(AF, 32'h0);
         tick(t / 2 + t / 8);
         rd(AF, 32'h200);
         wr(mfit_pkg::OFF_TIME_BASE_ONE_CONTROL, 32'h0);
      end
      wr(AF, 32'h0);
      tick(600);
      rd(AF, 32'h0);
      $display("test time base finished");
      wr(AS, 32'h3ff);
      for (int i = 0; i < 16; i++) begin
         for (int k = 0; k < 4; k++) g[k] = mfit_pkg::GRP_MASK[k][sbit(i)];
         wr(AF, 32'h0);
         wr(AG, 32'h0);
         pulse(16'h1 << i);
         rd(AF, 32'h1 << sbit(i));
         rd(AG, 32'(g));
      end
      // a frozen block must not record an event
      wr(AF, 32'h0);
      ce <= 1'b0;
      pulse(16'h0001);
      ce <= 1'b1;
      rd(AF, 32'h0);
      $display("test sources finished");
      wr(AS, 32'h0);
      wr(AF, 32'h40);
      low_power_mode <= 1'b1;
      tick(2);
      w = wakes;
      pulse(16'h0020);
      tick(4);
      cmp(34'(wakes - w), 34'h0);
      low_voltage_pin <= 1'b1;
      tick(8);
      cmp(34'(wakes - w), 34'h1);
      low_voltage_pin <= 1'b0;
      low_power_mode <= 1'b0;
      rd(AF, 32'h60);
      $display("test wake finished");
      wr(AF, 32'h0);
      wr(AG, 32'h0);
      wr(AS, 32'h3ff);
      wr(mfit_pkg::OFF_GEN, 32'hf);
      ack_en <= 1'b1;
      wr(AC, 32'h1);
      vq.push_back(34'h0);
      pulse(16'h0001);
      tick(4);
      rd(AC, 32'h2);
      rd(AG, 32'h0);
      rd(AF, 32'h1);
      back(1'b0);
      rd(AC, 32'h0);
      back(1'b1);
      rd(AC, 32'h1);
      wr(AC, 32'h0);
      pulse(16'h4030);
      tick(3);
      req_low();
      rd(AF, 32'h151);
      rd(AG, 32'hc);
      vq.push_back(34'h2);
      vq.push_back(34'h3);
      vq.push_back(34'h4);
      wr(AC, 32'h1);
      for (int i = 0; i < 3; i++) begin
         tick(4);
         back(1'b1);
      end
      rd(AF, 32'h51);
      vq.push_back(34'h1);
      pulse(16'h0002);
      tick(4);
      wr(AC, 32'h1);
      pulse(16'h0008);
      tick(3);
      req_low();
      vq.push_back(34'h1);
      back(1'b0);
      tick(4);
      back(1'b1);
      cmp(34'(vq.size()), 34'h0);
      $display("test vectoring finished");
      complete_run();
   end
endmodule
`default_nettype wire
